// file: logic/charger_defs.svh
// Offsets, field positions, reset values and timing figures of the supervisor
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH

`define CLK_HZ 50000000
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define TIMER_OFS 8'h08

`define CB_CHG_CFG 0
`define CB_TMR_EN 1
`define CB_HALF_EN 2
`define CB_FAST_SEL 3
`define CB_MON_LO 4
`define CB_MON_HI 5
`define CB_SW_DIS 6
`define CB_SHIP_DLY 7
`define CB_FSR_EN 8
`define CB_REG_RST 9
`define CTRL_RESET 32'h0000018F
`define CTRL_MASK 32'h000001FF
`define WDOG_KEEP_MASK 32'h000001C0

`define LOW_BAT_LIMIT_H 2
`define FAST_LONG_H 10
`define FAST_SHORT_H 5
`define SEC_PER_H 3600
`define BLINK_HZ 1
`define SHIP_DLY_MS 10000
`define SHIP_DEGLITCH_MS 1000
`define RST_HOLD_MS 8000
`define RST_OFF_MS 250

`endif

// file: logic/charger_pkg.sv
// Types shared by the charger supervisor modules
package charger_pkg;

  typedef struct packed {
    logic [2:0] src_type;
    logic ce_n;
    logic charging;
    logic adapter_present;
    logic bat_low;
    logic bat_above_sysmin;
    logic bat_depleted;
    logic sys_below_bat_180mv;
    logic sys_below_bat_45mv;
    logic sys_at_min;
    logic vindpm;
    logic iindpm;
    logic cool_reduce;
    logic therm_reg;
    logic boost_req;
    logic temp_ok;
    logic ts_fault;
    logic input_ov;
    logic sys_ov;
    logic vbus_uvlo_ok;
    logic vbus_above_bat;
    logic vbus_below_ov;
    logic vbus_not_poor;
    logic detect_done;
  } pwr_status_t;

  typedef enum logic [1:0] {
    SHIP_ON = 2'b00,
    SHIP_WAIT = 2'b01,
    SHIP_OFF = 2'b11
  } ship_state_t;

  typedef enum logic [1:0] {
    BTN_IDLE = 2'b00,
    BTN_OFF = 2'b01,
    BTN_WAIT_HIGH = 2'b11
  } btn_state_t;

endpackage

// file: logic/pin_sync.sv
// Three-stage pin synchroniser that accepts a level once two stages agree
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic changed
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] dout_next;

  // A bit moves only where the second and third stages agree
  assign dout_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (dout & (s2_reg ^ s3_reg));

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      dout <= INIT;
      changed <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout <= dout_next;
      changed <= |(dout_next ^ dout);
    end
  end

endmodule

// file: logic/charger_supervisor.sv
// Charger supervisor: safety timer, shipping mode, button reset, indicators
// What this block does
// - Boost stops outside temperature window; source field reads 000, fault flagged
// - Safety limit 2 h below low battery, host-selected fast limit above
// - Timer expiry writes 11 to charge fault field and pulses host
// - Timer enable bit off: no counting and no expiry fault
// - Regulation or cool reduction halves the timer counting rate
// - Half-rate enable at 0 forces full-rate counting
// - Timer holds its count while a charge fault is present
// - Charge stop and restart clears the timer
// - System regulation flag shows the rail held at minimum
// - Voltage and current limit flags follow dynamic power management
// - Supplement mode entered at 180 mV or 45 mV rail drop
// - Battery depletion ends supplement mode
// - Switch disable turns switch off at once or after delay
// - Adapter, bit clear, register reset or long button press exit shipping
// - Button held low on battery cycles the switch off then on
// - Full system reset enable at 0 skips button reset
// - Power good needs all five input source conditions
// - Charge monitor field 11 releases the status pin
// - Status pin low while charging, released otherwise
// - Status pin blinks at 1 Hz on charge or boost suspension
// - Watchdog expiry resets registers but keeps shipping and reset bits
`include "charger_defs.svh"

module charger_supervisor #(
  parameter int unsigned TICK_CYCLES = `CLK_HZ,
  parameter int unsigned BLINK_CYCLES = `CLK_HZ / (2 * `BLINK_HZ),
  parameter int unsigned SHIP_DLY_CYCLES = `SHIP_DLY_MS * (`CLK_HZ / 1000),
  parameter int unsigned DEGLITCH_CYCLES =
    `SHIP_DEGLITCH_MS * (`CLK_HZ / 1000),
  parameter int unsigned HOLD_CYCLES = `RST_HOLD_MS * (`CLK_HZ / 1000),
  parameter int unsigned OFF_CYCLES = `RST_OFF_MS * (`CLK_HZ / 1000)
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire charger_pkg::pwr_status_t PWR_STATUS,
  input wire logic WDOG_EXPIRED,
  input wire logic BUTTON_N,
  input wire logic STAT_I,
  output logic STAT_O,
  output logic STAT_OE,
  output logic PG_N,
  output logic BATT_SWITCH_ON,
  output logic BOOST_RUN,
  output logic TIMER_FAULT_PULSE
);

  // Limits in half-second units so the half rate needs no fractions
  localparam logic [17:0] LOW_LIMIT =
    18'(`LOW_BAT_LIMIT_H * `SEC_PER_H * 2);
  localparam logic [17:0] LONG_LIMIT = 18'(`FAST_LONG_H * `SEC_PER_H * 2);
  localparam logic [17:0] SHORT_LIMIT =
    18'(`FAST_SHORT_H * `SEC_PER_H * 2);

  logic [$bits(charger_pkg::pwr_status_t)-1:0] st_bits;
  charger_pkg::pwr_status_t st;
  logic btn_level;
  logic btn_changed;
  logic stat_level;
  logic [31:0] ctrl_reg;
  logic [31:0] status_word;
  logic [31:0] read_mux;
  logic addr_ok;
  logic ctrl_wr;
  logic chg_on;
  logic chg_on_d_reg;
  logic restart;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic half;
  logic fault_present;
  logic counting;
  logic [17:0] limit;
  logic [17:0] chg_cnt_reg;
  logic timer_expired_reg;
  logic expire_set;
  logic boost_susp;
  logic [2:0] src_field;
  logic [1:0] fault_field;
  logic supp_reg;
  charger_pkg::ship_state_t ship_state_reg;
  charger_pkg::btn_state_t btn_state_reg;
  logic [31:0] ship_cnt_reg;
  logic [31:0] btn_cnt_reg;
  logic [31:0] off_cnt_reg;
  logic btn_ship_exit;
  logic btn_hold;
  logic ship_exit_hw;
  logic pg_next;
  logic [31:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic blink_cond;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  pin_sync #(.W($bits(charger_pkg::pwr_status_t)), .INIT('0)) u_stat_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .din(PWR_STATUS),
    .dout(st_bits),
    .changed()
  );
  assign st = st_bits;

  pin_sync #(.W(1), .INIT(1'b1)) u_btn_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .din(BUTTON_N),
    .dout(btn_level),
    .changed(btn_changed)
  );

  pin_sync #(.W(1), .INIT(1'b1)) u_pin_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .din(STAT_I),
    .dout(stat_level),
    .changed()
  );

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign addr_ok = (PADDR == `CTRL_OFS) || (PADDR == `STATUS_OFS) ||
                   (PADDR == `TIMER_OFS);
  assign ctrl_wr = PSEL & PENABLE & PWRITE & (PADDR == `CTRL_OFS);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  assign status_word = {17'h00000, timer_expired_reg, stat_level,
                        ship_state_reg == charger_pkg::SHIP_OFF,
                        BATT_SWITCH_ON, supp_reg, fault_field,
                        boost_susp, st.iindpm, st.vindpm,
                        st.sys_at_min, ~PG_N, src_field};

  always_comb begin
    read_mux = 32'h00000000;
    if (PADDR == `CTRL_OFS) begin
      read_mux = ctrl_reg;
    end else if (PADDR == `STATUS_OFS) begin
      read_mux = status_word;
    end else if (PADDR == `TIMER_OFS) begin
      read_mux = {14'h0000, chg_cnt_reg};
    end
  end

  // Read data is caught in the setup phase so it stands in the access phase
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      PRDATA <= read_mux;
    end
  end

  // Hardware clearing of the disable bit loses to a host write in the
  // same cycle; the host's intent is the newer one.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (ctrl_wr & PWDATA[`CB_REG_RST]) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= PWDATA & `CTRL_MASK;
    end else if (WDOG_EXPIRED) begin
      ctrl_reg <= (`CTRL_RESET & ~`WDOG_KEEP_MASK) |
                  (ctrl_reg & `WDOG_KEEP_MASK);
    end else if (ship_exit_hw) begin
      ctrl_reg[`CB_SW_DIS] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Charge safety timer
  // ----------------------------------------------------------------
  assign chg_on = ctrl_reg[`CB_CHG_CFG] & ~st.ce_n;
  assign restart = chg_on & ~chg_on_d_reg;
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  assign half = ctrl_reg[`CB_HALF_EN] &
                (st.vindpm | st.iindpm | st.cool_reduce | st.therm_reg);
  assign fault_present = st.input_ov | st.ts_fault | st.sys_ov;
  assign counting = tick & ctrl_reg[`CB_TMR_EN] & st.charging &
                    ~fault_present & ~timer_expired_reg & ~restart;
  assign limit = st.bat_low ? LOW_LIMIT :
                 (ctrl_reg[`CB_FAST_SEL] ? LONG_LIMIT : SHORT_LIMIT);
  assign expire_set = ctrl_reg[`CB_TMR_EN] & ~timer_expired_reg &
                      ~restart & (chg_cnt_reg >= limit);
  assign fault_field = timer_expired_reg ? 2'h3 :
                       (st.input_ov ? 2'h1 : 2'h0);

  always_ff @(posedge CLK) begin
    if (SYS_RST || tick) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      chg_on_d_reg <= 1'b0;
      chg_cnt_reg <= 18'h00000;
      timer_expired_reg <= 1'b0;
      TIMER_FAULT_PULSE <= 1'b0;
    end else begin
      chg_on_d_reg <= chg_on;
      TIMER_FAULT_PULSE <= expire_set;
      if (restart) begin
        chg_cnt_reg <= 18'h00000;
        timer_expired_reg <= 1'b0;
      end else begin
        if (counting) begin
          chg_cnt_reg <= chg_cnt_reg + (half ? 18'h00001 : 18'h00002);
        end
        if (expire_set) begin
          timer_expired_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Boost thermistor watch and supplement mode
  // ----------------------------------------------------------------
  assign boost_susp = st.boost_req & ~st.temp_ok;
  assign src_field = boost_susp ? 3'h0 : st.src_type;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      BOOST_RUN <= 1'b0;
    end else begin
      BOOST_RUN <= st.boost_req & st.temp_ok;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      supp_reg <= 1'b0;
    end else if (st.bat_depleted) begin
      supp_reg <= 1'b0;
    end else if (st.bat_above_sysmin ? st.sys_below_bat_180mv :
                 st.sys_below_bat_45mv) begin
      supp_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Push-button timing
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST || btn_changed) begin
      btn_cnt_reg <= 32'h00000000;
    end else if (btn_cnt_reg != 32'hFFFFFFFF) begin
      btn_cnt_reg <= btn_cnt_reg + 32'h00000001;
    end
  end

  // Equality gives one event per press, not one per cycle held
  assign btn_ship_exit = ~btn_level & ~btn_changed &
                         (btn_cnt_reg == 32'(DEGLITCH_CYCLES - 1));
  assign btn_hold = ~btn_level & ~btn_changed &
                    (btn_cnt_reg == 32'(HOLD_CYCLES - 1));

  // ----------------------------------------------------------------
  // Shipping mode
  // ----------------------------------------------------------------
  assign ship_exit_hw = (ship_state_reg == charger_pkg::SHIP_OFF) &
                        (st.adapter_present | btn_ship_exit);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ship_state_reg <= charger_pkg::SHIP_ON;
      ship_cnt_reg <= 32'h00000000;
    end else begin
      ship_cnt_reg <= ship_cnt_reg + 32'h00000001;
      unique case (ship_state_reg)
        charger_pkg::SHIP_ON: begin
          ship_cnt_reg <= 32'h00000000;
          if (ctrl_reg[`CB_SW_DIS]) begin
            ship_state_reg <= ctrl_reg[`CB_SHIP_DLY] ?
                              charger_pkg::SHIP_WAIT :
                              charger_pkg::SHIP_OFF;
          end
        end
        charger_pkg::SHIP_WAIT: begin
          if (!ctrl_reg[`CB_SW_DIS]) begin
            ship_state_reg <= charger_pkg::SHIP_ON;
          end else if (ship_cnt_reg == 32'(SHIP_DLY_CYCLES - 1)) begin
            ship_state_reg <= charger_pkg::SHIP_OFF;
          end
        end
        charger_pkg::SHIP_OFF: begin
          if (!ctrl_reg[`CB_SW_DIS] || ship_exit_hw) begin
            ship_state_reg <= charger_pkg::SHIP_ON;
          end
        end
        default: begin
          ship_state_reg <= charger_pkg::SHIP_ON;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Push-button full system reset
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      btn_state_reg <= charger_pkg::BTN_IDLE;
      off_cnt_reg <= 32'h00000000;
    end else begin
      off_cnt_reg <= off_cnt_reg + 32'h00000001;
      unique case (btn_state_reg)
        charger_pkg::BTN_IDLE: begin
          off_cnt_reg <= 32'h00000000;
          if (btn_hold && !st.adapter_present &&
              !ctrl_reg[`CB_SW_DIS] && ctrl_reg[`CB_FSR_EN]) begin
            btn_state_reg <= charger_pkg::BTN_OFF;
          end
        end
        charger_pkg::BTN_OFF: begin
          if (off_cnt_reg == 32'(OFF_CYCLES - 1)) begin
            btn_state_reg <= charger_pkg::BTN_WAIT_HIGH;
          end
        end
        charger_pkg::BTN_WAIT_HIGH: begin
          // Rearm only after release so one press resets once
          if (btn_level) begin
            btn_state_reg <= charger_pkg::BTN_IDLE;
          end
        end
        default: begin
          btn_state_reg <= charger_pkg::BTN_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Battery switch, power good and status pin
  // ----------------------------------------------------------------
  assign pg_next = st.vbus_uvlo_ok & st.vbus_above_bat & st.vbus_below_ov &
                   st.vbus_not_poor & st.detect_done;
  assign blink_cond = st.input_ov | st.ts_fault | timer_expired_reg |
                      st.sys_ov | boost_susp;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      BATT_SWITCH_ON <= 1'b0;
      PG_N <= 1'b1;
    end else begin
      BATT_SWITCH_ON <= (ship_state_reg != charger_pkg::SHIP_OFF) &&
                        (btn_state_reg != charger_pkg::BTN_OFF) &&
                        (supp_reg || st.charging ||
                         (!st.adapter_present && !st.bat_depleted));
      PG_N <= ~pg_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_reg <= 32'h00000000;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      blink_phase_reg <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
      blink_phase_reg <= ~blink_phase_reg;
    end
  end

  assign STAT_O = 1'b0;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      STAT_OE <= 1'b0;
    end else if (ctrl_reg[`CB_MON_HI:`CB_MON_LO] == 2'h3) begin
      STAT_OE <= 1'b0;
    end else if (blink_cond) begin
      STAT_OE <= blink_phase_reg;
    end else begin
      STAT_OE <= st.charging;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_boost_ts_stop: assert property (boost_susp |=> !BOOST_RUN)
    else $error("boost ran outside temperature window");
  a_timer_expiry: assert property (expire_set |=>
    fault_field == 2'h3 && TIMER_FAULT_PULSE ##1 !TIMER_FAULT_PULSE)
    else $error("expiry not reported as fault 11 with one pulse");
  a_timer_off: assert property (!ctrl_reg[`CB_TMR_EN] && !restart |=>
    $stable(chg_cnt_reg) && !$rose(timer_expired_reg))
    else $error("disabled timer moved");
  a_half_rate: assert property (counting && half |=>
    chg_cnt_reg == 18'($past(chg_cnt_reg) + 18'h00001))
    else $error("half rate step wrong");
  a_full_rate: assert property (counting && !ctrl_reg[`CB_HALF_EN] |=>
    chg_cnt_reg == 18'($past(chg_cnt_reg) + 18'h00002))
    else $error("full rate step wrong");
  a_fault_hold: assert property (fault_present && !restart |=>
    $stable(chg_cnt_reg))
    else $error("timer counted during fault");
  a_restart_clr: assert property (restart |=>
    chg_cnt_reg == 18'h00000 && !timer_expired_reg)
    else $error("restart did not clear timer");
  a_supp_exit: assert property (st.bat_depleted |=> !supp_reg)
    else $error("supplement held on depleted battery");
  a_ship_now: assert property (ship_state_reg == charger_pkg::SHIP_ON &&
    ctrl_reg[`CB_SW_DIS] && !ctrl_reg[`CB_SHIP_DLY] |=>
    ship_state_reg == charger_pkg::SHIP_OFF ##1 !BATT_SWITCH_ON)
    else $error("switch not turned off at once");
  a_fsr_skip: assert property (!ctrl_reg[`CB_FSR_EN] &&
    btn_state_reg == charger_pkg::BTN_IDLE |=>
    btn_state_reg == charger_pkg::BTN_IDLE)
    else $error("button reset ran while disabled");
  a_pg_pin: assert property (pg_next |=> !PG_N)
    else $error("power good not shown");
  a_stat_off: assert property (
    ctrl_reg[`CB_MON_HI:`CB_MON_LO] == 2'h3 |=> !STAT_OE)
    else $error("status pin driven while disabled");

  c_timer_expiry: cover property (expire_set);
  c_ship_off: cover property (ship_state_reg == charger_pkg::SHIP_OFF);
  c_button_reset: cover property (btn_state_reg == charger_pkg::BTN_OFF);

endmodule

// file: verification/power_stage_model.sv
// Power stage, push-button and status pin pull-up facing the supervisor
module power_stage_model (
  input wire logic clk,
  input wire charger_pkg::pwr_status_t next_status,
  input wire logic press,
  input wire logic stat_o,
  input wire logic stat_oe,
  output charger_pkg::pwr_status_t status,
  output logic button_n,
  output logic stat_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial status = '0;
  initial button_n = 1'b1;
  // Levels move only just after a rising edge, as a sampled source would
  always @(posedge clk) begin
    status <= next_status;
    button_n <= ~press;
  end
  // Pull-up: a released pin reads high, never its last driven level
  assign stat_pin = stat_oe ? stat_o : 1'b1;
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the charger supervisor
`include "charger_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wdog = 1'b0;
  logic press = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, stat_o, stat_oe, pg_n, sw_on, boost, tfp;
  logic button_n, stat_pin, e;
  logic [31:0] q;
  charger_pkg::pwr_status_t ns = '0;
  charger_pkg::pwr_status_t ps;
  int err_count = 0;
  int comparisons = 0;
  localparam logic [31:0] BASE = 32'h0000010F;
  always #10 clk = ~clk;

  charger_supervisor #(.TICK_CYCLES(10), .BLINK_CYCLES(4),
    .SHIP_DLY_CYCLES(20), .DEGLITCH_CYCLES(8), .HOLD_CYCLES(30),
    .OFF_CYCLES(10)) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PWR_STATUS(ps),
    .WDOG_EXPIRED(wdog), .BUTTON_N(button_n), .STAT_I(stat_pin),
    .STAT_O(stat_o), .STAT_OE(stat_oe), .PG_N(pg_n),
    .BATT_SWITCH_ON(sw_on), .BOOST_RUN(boost), .TIMER_FAULT_PULSE(tfp));

  power_stage_model i_stage (.clk(clk), .next_status(ns), .press(press),
    .stat_o(stat_o), .stat_oe(stat_oe), .status(ps),
    .button_n(button_n), .stat_pin(stat_pin));

  // ----------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Ends on a falling edge so registered outputs have settled
  task automatic mid(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge clk);
  endtask

  task automatic rate(input logic [31:0] exp);
    logic [31:0] a;
    cyc(8);
    apb(1'b0, `TIMER_OFS, 32'h0);
    a = q;
    cyc(97);
    apb(1'b0, `TIMER_OFS, 32'h0);
    check(q - a, exp);
  endtask

  function automatic logic [31:0] wd_exp(input logic [31:0] w);
    return (`CTRL_RESET & ~`WDOG_KEEP_MASK) | (w & `WDOG_KEEP_MASK);
  endfunction

  initial begin
    #(90000 * 20);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] r;
    int n;
    r = $urandom(32'h62132c63);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `CTRL_OFS, 32'h0);
    check(q, `CTRL_RESET);
    apb(1'b0, 8'h0C, 32'h0);
    check({q[31:1], e}, 32'h1);
    apb(1'b1, `CTRL_OFS, 32'h80);
    wdog <= 1'b1;
    cyc(1);
    wdog <= 1'b0;
    cyc(1);
    apb(1'b0, `CTRL_OFS, 32'h0);
    check(q, wd_exp(32'h80));
    for (int i = 0; i < 6; i++) begin
      ns[4:0] <= (i == 5) ? 5'h1F : 5'h1F ^ (5'h01 << i);
      mid(8);
      check(32'(pg_n), (i == 5) ? 32'h0 : 32'h1);
      cyc(1);
    end
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(32'(q[3]), 32'h1);
    for (int i = 0; i < 8; i++) begin
      r = $urandom();
      ns.sys_at_min <= r[0];
      ns.vindpm <= r[1];
      ns.iindpm <= r[2];
      cyc(8);
      apb(1'b0, `STATUS_OFS, 32'h0);
      check(32'(q[6:4]), 32'(r[2:0]));
    end
    ns.bat_above_sysmin <= 1'b1;
    ns.sys_below_bat_180mv <= 1'b1;
    cyc(8);
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(32'(q[10]), 32'h1);
    ns.bat_depleted <= 1'b1;
    cyc(8);
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(32'(q[10]), 32'h0);
    ns.bat_depleted <= 1'b0;
    ns.sys_below_bat_180mv <= 1'b0;
    ns.src_type <= r[5:3] | 3'h1;
    ns.boost_req <= 1'b1;
    ns.temp_ok <= 1'b1;
    mid(8);
    check(32'(boost), 32'h1);
    cyc(1);
    ns.temp_ok <= 1'b0;
    mid(8);
    check(32'(boost), 32'h0);
    n = 0;
    r[0] = stat_oe;
    repeat (20) begin
      @(negedge clk);
      n += (stat_oe !== r[0]);
      r[0] = stat_oe;
    end
    check(32'(n >= 2), 32'h1);
    cyc(1);
    apb(1'b0, `STATUS_OFS, 32'h0);
    r = {24'h0, 1'b1, ns.iindpm, ns.vindpm, ns.sys_at_min, 4'h8};
    check({24'h0, q[7:0]}, r);
    ns.temp_ok <= 1'b1;
    mid(8);
    check(32'(boost), 32'h1);
    cyc(1);
    ns.boost_req <= 1'b0;
    ns.bat_low <= 1'b1;
    ns.charging <= 1'b1;
    apb(1'b1, `CTRL_OFS, BASE);
    mid(8);
    check({31'h0, stat_pin}, 32'h0);
    cyc(1);
    apb(1'b1, `CTRL_OFS, BASE | 32'h30);
    mid(3);
    check(32'(stat_oe), 32'h0);
    cyc(1);
    apb(1'b1, `CTRL_OFS, BASE);
    ns.vindpm <= 1'b0;
    ns.iindpm <= 1'b0;
    rate(32'd20);
    ns.vindpm <= 1'b1;
    rate(32'd10);
    apb(1'b1, `CTRL_OFS, BASE & ~32'h4);
    rate(32'd20);
    ns.ts_fault <= 1'b1;
    rate(32'd0);
    ns.ts_fault <= 1'b0;
    apb(1'b1, `CTRL_OFS, BASE & ~32'h2);
    rate(32'd0);
    apb(1'b1, `CTRL_OFS, BASE & ~32'h1);
    apb(1'b1, `CTRL_OFS, BASE);
    apb(1'b0, `TIMER_OFS, 32'h0);
    check(32'(q < 32'd8), 32'h1);
    ns.charging <= 1'b0;
    apb(1'b1, `CTRL_OFS, BASE | 32'h40);
    mid(3);
    check(32'(sw_on), 32'h0);
    cyc(1);
    apb(1'b1, `CTRL_OFS, BASE);
    mid(3);
    check(32'(sw_on), 32'h1);
    cyc(1);
    apb(1'b1, `CTRL_OFS, BASE | 32'hC0);
    mid(10);
    check(32'(sw_on), 32'h1);
    mid(15);
    check(32'(sw_on), 32'h0);
    cyc(1);
    press <= 1'b1;
    mid(20);
    check(32'(sw_on), 32'h1);
    cyc(1);
    press <= 1'b0;
    apb(1'b1, `CTRL_OFS, BASE | 32'h40);
    ns.adapter_present <= 1'b1;
    ns.charging <= 1'b1;
    mid(8);
    check(32'(sw_on), 32'h1);
    cyc(1);
    ns.adapter_present <= 1'b0;
    ns.charging <= 1'b0;
    cyc(8);
    apb(1'b1, `CTRL_OFS, BASE | 32'h40);
    apb(1'b1, `CTRL_OFS, 32'h200);
    mid(3);
    check(32'(sw_on), 32'h1);
    cyc(1);
    apb(1'b0, `CTRL_OFS, 32'h0);
    check(q, `CTRL_RESET);
    press <= 1'b1;
    mid(20);
    check(32'(sw_on), 32'h1);
    mid(18);
    check(32'(sw_on), 32'h0);
    mid(17);
    check(32'(sw_on), 32'h1);
    cyc(1);
    press <= 1'b0;
    apb(1'b1, `CTRL_OFS, BASE & ~32'h100);
    cyc(5);
    press <= 1'b1;
    mid(38);
    check(32'(sw_on), 32'h1);
    cyc(1);
    press <= 1'b0;
    ns.vindpm <= 1'b0;
    ns.charging <= 1'b1;
    apb(1'b1, `CTRL_OFS, BASE & ~32'h1);
    apb(1'b1, `CTRL_OFS, BASE);
    // Restart by the charge-enable pin after the count has grown
    cyc(200);
    ns.ce_n <= 1'b1;
    cyc(8);
    ns.ce_n <= 1'b0;
    cyc(8);
    apb(1'b0, `TIMER_OFS, 32'h0);
    check(32'(q < 32'd8), 32'h1);
    // Two-hour limit at full rate: long but the only end-to-end expiry
    n = 0;
    while (tfp !== 1'b1 && n < 80000) begin
      @(negedge clk);
      n++;
    end
    check(32'(tfp), 32'h1);
    cyc(1);
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(32'(q[9:8]), 32'h3);
    report_and_stop();
  end
endmodule
